// *** rtl/dcc_top.sv ***
// Dual comparator control: registers, result status, interrupt flags
// What this block does
// - Two channels, each with own control register
// - Enable bit 7 switches comparator on
// - Bit 6 routes result to output pin
// - Raw result high when positive exceeds negative
// - Bit 5 inverts result everywhere downstream
// - Bits 4-3 choose interrupt edge
// - Bit 2 picks pin or ladder reference
// - Bits 1-0 steer the inverting input
// - Inverting sources: pin, second pin, charge unit, fixed
// - Status bits 1-0 hold results, rest zero
// - Each channel raises its own event
// - Flags sticky; writing one to flag register clears flag, to force register sets it
// - Reset returns control registers, comparators off
// - Edge code 00 raises no flag
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,

  // Register port
  input wire dcc_bus_req_s bus_req,
  output logic [7:0] rd_data,

  // Analog comparator cores
  input wire logic [1:0] raw_gt,
  output dcc_analog_s analog_one,
  output dcc_analog_s analog_two,

  // Remappable output pins
  output logic [1:0] comparator_output_pin,
  output logic [1:0] comparator_output_pin_oe,

  // Interrupt
  output logic irq
);

  typedef struct packed {
    dcc_ctrl_s [1:0] ctrl;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [7:0] rd_data;
    logic irq;
    logic [1:0] pin;
    logic [1:0] pin_oe;
    dcc_analog_s [1:0] analog;
  } dcc_top_s;

  dcc_top_s st;
  dcc_top_s next_st;

  logic [1:0] sync_gt;
  logic [1:0] result;
  logic [1:0] event_pulse;
  logic [1:0] clear_bits;
  logic [1:0] force_bits;
  logic [1:0] wr_hit;

  // Decode of a written address to a channel control slot
  function automatic logic [1:0] ctrl_hit(input logic [11:0] addr);
    logic [1:0] hit;
    hit = 2'h0;
    hit[0] = (addr == DCC_ADDR_CTRL_A);
    hit[1] = (addr == DCC_ADDR_CTRL_B);
    return hit;
  endfunction

  // Inverting-input selection as one-hot for the analog mux
  function automatic logic [3:0] nsel_onehot(input dcc_nsel_e sel);
    logic [3:0] oh;
    oh = 4'h0;
    case (sel)
      DCC_NSEL_PIN: oh = 4'h1;
      DCC_NSEL_ALT_PIN: oh = 4'h2;
      DCC_NSEL_CHARGE: oh = 4'h4;
      DCC_NSEL_FIXED: oh = 4'h8;
      default: oh = 4'h8;
    endcase
    return oh;
  endfunction

  // Raw results are asynchronous to the clock
  dcc_sync #(
    .WIDTH(DCC_NUM_CH)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .raw_in(raw_gt),
    .sync_out(sync_gt)
  );

  genvar gi;
  generate
    for (gi = 0; gi < DCC_NUM_CH; gi++)
    begin : g_chan
      dcc_chan u_chan (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .ctrl(st.ctrl[gi]),
        .sync_gt(sync_gt[gi]),
        .result(result[gi]),
        .event_pulse(event_pulse[gi])
      );
    end
  endgenerate

  // Write-side decode of the flag register and the force register
  always_comb
  begin
    clear_bits = 2'h0;
    force_bits = 2'h0;
    if (bus_req.wr)
    begin
      if (bus_req.addr == DCC_ADDR_FLAGS)
      begin
        clear_bits = bus_req.wdata[1:0];
      end
      if (bus_req.addr == DCC_ADDR_FORCE)
      begin
        force_bits = bus_req.wdata[1:0];
      end
    end
  end

  always_comb
  begin
    next_st = st;
    wr_hit = ctrl_hit(bus_req.addr);

    // Control registers: each slot written alone
    if (bus_req.wr)
    begin
      for (int i = 0; i < DCC_NUM_CH; i++)
      begin
        if (wr_hit[i])
        begin
          next_st.ctrl[i] = dcc_ctrl_s'(bus_req.wdata);
        end
      end
      if (bus_req.addr == DCC_ADDR_MASK)
      begin
        next_st.mask = bus_req.wdata[1:0];
      end
    end

    // A new event wins over a clear in the same cycle
    next_st.flags = (st.flags & ~clear_bits) | event_pulse | force_bits;

    // Level interrupt, one cycle behind the flag
    next_st.irq = |(st.flags & st.mask);

    // Read data valid in the cycle after the strobe only
    next_st.rd_data = 8'h00;
    if (bus_req.rd)
    begin
      case (bus_req.addr)
        DCC_ADDR_RESULT: next_st.rd_data = {6'h00, result[1], result[0]};
        DCC_ADDR_CTRL_A: next_st.rd_data = 8'(st.ctrl[0]);
        DCC_ADDR_CTRL_B: next_st.rd_data = 8'(st.ctrl[1]);
        DCC_ADDR_FLAGS: next_st.rd_data = {6'h00, st.flags};
        DCC_ADDR_MASK: next_st.rd_data = {6'h00, st.mask};
        default: next_st.rd_data = 8'h00;
      endcase
    end

    // Pin and analog steering follow the stored configuration
    for (int i = 0; i < DCC_NUM_CH; i++)
    begin
      next_st.pin_oe[i] = next_st.ctrl[i].output_pin_enable;
      next_st.pin[i] = next_st.ctrl[i].output_pin_enable & result[i];
      next_st.analog[i].comparator_on = next_st.ctrl[i].comparator_on;
      next_st.analog[i].positive_ref_select = next_st.ctrl[i].positive_ref_select;
      next_st.analog[i].negative_onehot = nsel_onehot(next_st.ctrl[i].negative_channel_select);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.ctrl[0] <= dcc_ctrl_s'(DCC_CTRL_RESET);
      st.ctrl[1] <= dcc_ctrl_s'(DCC_CTRL_RESET);
      st.flags <= DCC_FLAGS_RESET;
      st.mask <= DCC_MASK_RESET;
      // Steering mirrors the control reset value while reset is still asserted
      st.analog[0].positive_ref_select <= DCC_CTRL_RESET[DCC_BIT_PREF];
      st.analog[1].positive_ref_select <= DCC_CTRL_RESET[DCC_BIT_PREF];
      st.analog[0].negative_onehot <= 4'h8;
      st.analog[1].negative_onehot <= 4'h8;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data = st.rd_data;
  assign irq = st.irq;
  assign comparator_output_pin = st.pin;
  assign comparator_output_pin_oe = st.pin_oe;
  assign analog_one = st.analog[0];
  assign analog_two = st.analog[1];

endmodule

// *** shared/dcc_pkg.sv ***
// Package: register map, field layouts and carriers of the comparator control block
package dcc_pkg;

  localparam int DCC_ADDR_W = 12;
  localparam int DCC_DATA_W = 8;
  localparam int DCC_NUM_CH = 2;

  // Register byte offsets
  localparam logic [11:0] DCC_ADDR_RESULT = 12'hF70;
  localparam logic [11:0] DCC_ADDR_CTRL_B = 12'hFD1;
  localparam logic [11:0] DCC_ADDR_CTRL_A = 12'hFD2;
  localparam logic [11:0] DCC_ADDR_FLAGS = 12'hF80;
  localparam logic [11:0] DCC_ADDR_MASK = 12'hF81;
  localparam logic [11:0] DCC_ADDR_FORCE = 12'hF82;

  // Field positions inside a control register
  localparam int DCC_BIT_ON = 7;
  localparam int DCC_BIT_OE = 6;
  localparam int DCC_BIT_INV = 5;
  localparam int DCC_BIT_EDGE_HI = 4;
  localparam int DCC_BIT_EDGE_LO = 3;
  localparam int DCC_BIT_PREF = 2;
  localparam int DCC_BIT_NSEL_HI = 1;
  localparam int DCC_BIT_NSEL_LO = 0;

  // Values after reset
  localparam logic [7:0] DCC_CTRL_RESET = 8'h1F;
  localparam logic [1:0] DCC_MASK_RESET = 2'h0;
  localparam logic [1:0] DCC_FLAGS_RESET = 2'h0;

  typedef enum logic [1:0] {
    DCC_EDGE_NONE = 2'b00,
    DCC_EDGE_RISE = 2'b01,
    DCC_EDGE_FALL = 2'b10,
    DCC_EDGE_ANY = 2'b11
  } dcc_edge_e;

  typedef enum logic [1:0] {
    DCC_NSEL_PIN = 2'b00,
    DCC_NSEL_ALT_PIN = 2'b01,
    DCC_NSEL_CHARGE = 2'b10,
    DCC_NSEL_FIXED = 2'b11
  } dcc_nsel_e;

  typedef struct packed {
    logic comparator_on;
    logic output_pin_enable;
    logic output_invert;
    dcc_edge_e interrupt_edge_select;
    logic positive_ref_select;
    dcc_nsel_e negative_channel_select;
  } dcc_ctrl_s;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dcc_bus_req_s;

  // Analog-side steering for one comparator
  typedef struct packed {
    logic comparator_on;
    logic positive_ref_select;
    logic [3:0] negative_onehot;
  } dcc_analog_s;

endpackage

// *** rtl/dcc_sync.sv ***
// Two-stage synchroniser for the raw comparator results
`timescale 1ns/1ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = DCC_NUM_CH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] raw_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } dcc_sync_s;

  dcc_sync_s st;
  dcc_sync_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.stage1 = raw_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign sync_out = st.stage2;

endmodule

// *** rtl/dcc_chan.sv ***
// One comparator channel: polarity and edge-selected event
`timescale 1ns/1ps
module dcc_chan
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Configuration and synchronised raw result
  input wire dcc_ctrl_s ctrl,
  input wire logic sync_gt,
  // Results
  output logic result,
  output logic event_pulse
);

  typedef struct packed {
    logic result;
    logic event_pulse;
  } dcc_chan_s;

  dcc_chan_s st;
  dcc_chan_s next_st;
  logic adj;
  logic rise;
  logic fall;

  always_comb
  begin
    // A switched-off comparator reads as a low raw result
    adj = (ctrl.comparator_on & sync_gt) ^ ctrl.output_invert;
    rise = adj & ~st.result;
    fall = ~adj & st.result;
    next_st = st;
    next_st.result = adj;
    next_st.event_pulse = 1'b0;
    if (ctrl.comparator_on)
    begin
      case (ctrl.interrupt_edge_select)
        DCC_EDGE_RISE: next_st.event_pulse = rise;
        DCC_EDGE_FALL: next_st.event_pulse = fall;
        DCC_EDGE_ANY: next_st.event_pulse = rise | fall;
        DCC_EDGE_NONE: next_st.event_pulse = 1'b0;
        default: next_st.event_pulse = 1'b0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign result = st.result;
  assign event_pulse = st.event_pulse;

endmodule

// *** testbench/dcc_analog_model.sv ***
// Behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module dcc_analog_model
  import dcc_pkg::*;
(
  // Steering from the block
  input wire dcc_analog_s analog_one,
  input wire dcc_analog_s analog_two,
  // Input levels per channel: positive {ladder,pin}, negative by source
  input wire logic [3:0] pos_lvl,
  input wire logic [7:0] neg_lvl,
  // Raw results
  output logic [1:0] raw_gt
);
  // Selected pins count as configured analog inputs
  // A core that is off drives low
  assign raw_gt[0] = analog_one.comparator_on & pos_lvl[analog_one.positive_ref_select] &
    ~|(neg_lvl[3:0] & analog_one.negative_onehot);
  assign raw_gt[1] = analog_two.comparator_on & pos_lvl[{1'b1, analog_two.positive_ref_select}] &
    ~|(neg_lvl[7:4] & analog_two.negative_onehot);
endmodule

// *** testbench/dcc_top_sva.sv ***
// Port assertions for the dual comparator control block
`timescale 1ns/1ps
module dcc_top_sva
  import dcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire dcc_bus_req_s bus_req,
  input wire logic [7:0] rd_data,
  // Analog side and pins
  input wire logic [1:0] raw_gt,
  input wire dcc_analog_s analog_one,
  input wire dcc_analog_s analog_two,
  input wire logic [1:0] comparator_output_pin,
  input wire logic [1:0] comparator_output_pin_oe,
  // Interrupt
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic wr_a = bus_req.wr && bus_req.addr == DCC_ADDR_CTRL_A;
  wire logic clr_wr = bus_req.wr && (bus_req.addr == DCC_ADDR_FLAGS || bus_req.addr == DCC_ADDR_MASK);
  // Quiet window so only the raw step moves the pin
  sequence raw_step;
    $changed(raw_gt[0]) && analog_one.comparator_on && comparator_output_pin_oe[0] && !bus_req.wr
    ##1 ($stable(raw_gt[0]) && !bus_req.wr)[*4];
  endsequence
  rd_idle_a: assert property (!$past(bus_req.rd) |-> rd_data == 8'h00)
    else $error("read data not idle");
  status_zero_a: assert property ($past(bus_req.rd) && $past(bus_req.addr) == DCC_ADDR_RESULT |->
    rd_data[7:2] == 6'h00) else $error("status upper bits set");
  ctrl_write_a: assert property (wr_a |=>
    analog_one.comparator_on == $past(bus_req.wdata[7]) && comparator_output_pin_oe[0] == $past(bus_req.wdata[6])
    && analog_one.positive_ref_select == $past(bus_req.wdata[2])) else $error("control fields wrong");
  nsel_steer_a: assert property (wr_a |=> analog_one.negative_onehot == 4'h1 << $past(bus_req.wdata[1:0]))
    else $error("inverting input steering wrong");
  chan_apart_a: assert property (wr_a |=> $stable(analog_two))
    else $error("channel two disturbed");
  pin_gate_a: assert property (!comparator_output_pin_oe[0] |-> !comparator_output_pin[0])
    else $error("pin driven while disabled");
  sync_delay_a: assert property (raw_step |-> comparator_output_pin[0] != $past(comparator_output_pin[0]))
    else $error("pin not following raw step");
  irq_hold_a: assert property (irq && !clr_wr && !$past(clr_wr) |=> irq)
    else $error("interrupt dropped");
endmodule
bind dcc_top dcc_top_sva chk (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
  .raw_gt(raw_gt), .analog_one(analog_one), .analog_two(analog_two), .comparator_output_pin(comparator_output_pin),
  .comparator_output_pin_oe(comparator_output_pin_oe), .irq(irq));

// *** testbench/test_dcc_top.sv ***
// Register-level test of the dual comparator control block
`timescale 1ns/1ps
module test_dcc_top;
  import dcc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dcc_bus_req_s bus_req = '0;
  logic [7:0] rd_data;
  logic [1:0] raw_gt;
  logic [1:0] comparator_output_pin;
  logic [1:0] comparator_output_pin_oe;
  logic irq;
  dcc_analog_s analog_one;
  dcc_analog_s analog_two;
  logic [3:0] pos_lvl = 4'hF;
  logic [7:0] neg_lvl = 8'h0A;
  int num_errors = 0;
  int tests_run = 0;
  always #12.5 ref_clk = ~ref_clk;
  dcc_top dut (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .raw_gt(raw_gt),
    .analog_one(analog_one), .analog_two(analog_two), .comparator_output_pin(comparator_output_pin),
    .comparator_output_pin_oe(comparator_output_pin_oe), .irq(irq));
  dcc_analog_model cores (.analog_one(analog_one), .analog_two(analog_two), .pos_lvl(pos_lvl),
    .neg_lvl(neg_lvl), .raw_gt(raw_gt));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 cmp(rd_data, exp);
  endtask
  // Margin over the three-edge result path
  task automatic settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #200000 num_errors++;
    tally_and_finish;
  end
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    reg_rd(DCC_ADDR_CTRL_A, 8'h1F);
    reg_rd(DCC_ADDR_CTRL_B, 8'h1F);
    cmp({7'h00, analog_one.comparator_on}, 8'h00);
    reg_rd(DCC_ADDR_RESULT, 8'h00);
    $display("reset test done");
    reg_wr(DCC_ADDR_CTRL_A, 8'hC0);
    settle;
    reg_rd(DCC_ADDR_RESULT, 8'h01);
    cmp({6'h00, comparator_output_pin}, 8'h01);
    reg_wr(DCC_ADDR_CTRL_A, 8'hE0);
    settle;
    reg_rd(DCC_ADDR_RESULT, 8'h00);
    cmp({comparator_output_pin, comparator_output_pin_oe}, 8'h01);
    reg_rd(DCC_ADDR_CTRL_B, 8'h1F);
    $display("polarity test done");
    for (int s = 0; s < 4; s++)
    begin
      reg_wr(DCC_ADDR_CTRL_A, 8'h80 | s[7:0]);
      settle;
      reg_rd(DCC_ADDR_RESULT, {7'h00, ~s[0]});
    end
    @(posedge ref_clk) pos_lvl <= 4'hD;
    reg_wr(DCC_ADDR_CTRL_A, 8'h84);
    settle;
    reg_rd(DCC_ADDR_RESULT, 8'h00);
    $display("steering test done");
    reg_wr(DCC_ADDR_MASK, 8'h03);
    for (int c = 0; c < 4; c++)
    begin
      @(posedge ref_clk) neg_lvl <= 8'h01;
      pos_lvl <= 4'hF;
      reg_wr(DCC_ADDR_CTRL_A, 8'h80 | (c[7:0] << 3));
      settle;
      reg_wr(DCC_ADDR_FLAGS, 8'h03);
      @(posedge ref_clk) neg_lvl <= 8'h00;
      settle;
      reg_rd(DCC_ADDR_FLAGS, {7'h00, c[0]});
      cmp({7'h00, irq}, {7'h00, c[0]});
      reg_wr(DCC_ADDR_FLAGS, 8'h03);
      @(posedge ref_clk) neg_lvl <= 8'h01;
      settle;
      reg_rd(DCC_ADDR_FLAGS, {7'h00, c[1]});
    end
    $display("edge test done");
    reg_wr(DCC_ADDR_FLAGS, 8'h03);
    reg_wr(DCC_ADDR_FORCE, 8'h02);
    reg_rd(DCC_ADDR_FLAGS, 8'h02);
    cmp({7'h00, irq}, 8'h01);
    reg_wr(DCC_ADDR_MASK, 8'h00);
    settle;
    cmp({7'h00, irq}, 8'h00);
    reg_rd(DCC_ADDR_FLAGS, 8'h02);
    reg_wr(DCC_ADDR_FLAGS, 8'h02);
    reg_rd(DCC_ADDR_FLAGS, 8'h00);
    $display("flag test done");
    reg_wr(DCC_ADDR_RESULT, 8'hFF);
    reg_rd(DCC_ADDR_RESULT, 8'h00);
    reg_rd(12'h123, 8'h00);
    $display("refusal test done");
    reg_wr(DCC_ADDR_CTRL_B, 8'hC0);
    settle;
    reg_rd(DCC_ADDR_RESULT, 8'h02);
    cmp({6'h00, comparator_output_pin}, 8'h02);
    cmp({2'h0, analog_two}, 8'h21);
    reg_rd(DCC_ADDR_FORCE, 8'h00);
    $display("channel two test done");
    tally_and_finish;
  end
endmodule
